// ---- design/partition_isolation_pkg.sv ----
package partition_isolation_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [0:0]  ISOLATION_CMD_OFFSET   = 1'h0;
  localparam logic [0:0]  ISOLATION_STATE_OFFSET = 1'h0;
  localparam int          CMD_BIT                = 0;
  localparam int          STATE_BIT              = 0;
  localparam logic        DECOUPLE_RESET         = 1'h0;

  // ==========================================================================
  // bus constants
  // ==========================================================================
  localparam int          DATA_W                 = 32;
  localparam logic [1:0]  RESP_OKAY              = 2'h0;
  localparam logic [1:0]  RESP_SLVERR            = 2'h2;

  // stream control word, only the low bit is meaningful
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } stream_word_t;

endpackage

// ---- design/partition_isolation_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module partition_isolation_control #(
  parameter int          TO_RP_W   = 8,             // static -> partition width
  parameter int          FROM_RP_W = 8,             // partition -> static width
  parameter logic [7:0]  TO_RP_SAFE   = 8'h00,
  parameter logic [7:0]  FROM_RP_SAFE = 8'h00
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_i,
  // register port
  input  wire logic                 reg_aresetn_i,
  input  wire logic                 reg_awaddr_i,
  input  wire logic                 reg_awvalid_i,
  output logic                      reg_awready_o,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wvalid_i,
  output logic                      reg_wready_o,
  output logic [1:0]                reg_bresp_o,
  output logic                      reg_bvalid_o,
  input  wire logic                 reg_bready_i,
  input  wire logic                 reg_araddr_i,
  input  wire logic                 reg_arvalid_i,
  output logic                      reg_arready_o,
  output logic [31:0]               reg_rdata_o,
  output logic [1:0]                reg_rresp_o,
  output logic                      reg_rvalid_o,
  input  wire logic                 reg_rready_i,
  // control and status streams
  input  wire logic                 ctrl_aresetn_i,
  input  wire logic                 ctrl_tvalid_i,
  output logic                      ctrl_tready_o,
  input  wire logic [31:0]          ctrl_tdata_i,
  output logic                      status_tvalid_o,
  output logic [31:0]               status_tdata_o,
  // level control and status
  input  wire logic                 decouple_i,
  output logic                      decouple_status_o,
  // isolated interface, partition side and static side
  input  wire logic [TO_RP_W-1:0]   s_to_rp_i,
  output logic      [TO_RP_W-1:0]   rp_to_rp_o,
  input  wire logic [FROM_RP_W-1:0] rp_from_rp_i,
  output logic      [FROM_RP_W-1:0] s_from_rp_o
);

  // ==========================================================================
  // command sources
  // ==========================================================================
  logic                         reg_cmd_ff;
  logic                         stream_cmd_ff;
  logic                         decoupled;
  partition_isolation_pkg::stream_word_t ctrl_word;

  assign ctrl_word = '{valid: ctrl_tvalid_i, data: ctrl_tdata_i};

  // any source can request isolation; sources are or-ed so none can undo another
  assign decoupled = reg_cmd_ff | stream_cmd_ff | decouple_i;

  // status pin is purely combinational so it can chain into another isolator
  assign decouple_status_o = decoupled;

  // ==========================================================================
  // register write channel
  // ==========================================================================
  logic        aw_seen_ff;
  logic        w_seen_ff;
  logic [31:0] wdata_ff;
  logic        awaddr_ff;
  logic        aw_take;
  logic        w_take;
  logic        do_write;

  // readies drop once a half is held or the answer waits: one write in flight
  assign reg_awready_o = ~aw_seen_ff & ~reg_bvalid_o;
  assign reg_wready_o  = ~w_seen_ff & ~reg_bvalid_o;
  assign aw_take       = reg_awvalid_i & reg_awready_o;
  assign w_take        = reg_wvalid_i & reg_wready_o;
  // address and data may arrive in either order or in the same cycle
  assign do_write      = (aw_seen_ff | aw_take) & (w_seen_ff | w_take);

  // address half held until its data partner arrives
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aw_seen_ff <= 1'h0;
    end
    else if (!reg_aresetn_i)
    begin
      aw_seen_ff <= 1'h0;
    end
    else if (do_write)
    begin
      aw_seen_ff <= 1'h0;
    end
    else if (aw_take)
    begin
      aw_seen_ff <= 1'h1;
    end
  end

  // data half held until its address partner arrives
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      w_seen_ff <= 1'h0;
    end
    else if (!reg_aresetn_i)
    begin
      w_seen_ff <= 1'h0;
    end
    else if (do_write)
    begin
      w_seen_ff <= 1'h0;
    end
    else if (w_take)
    begin
      w_seen_ff <= 1'h1;
    end
  end

  // captured address, only read back while the data half is still missing
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      awaddr_ff <= 1'h0;
    end
    else if (!reg_aresetn_i)
    begin
      awaddr_ff <= 1'h0;
    end
    else if (aw_take)
    begin
      awaddr_ff <= reg_awaddr_i;
    end
  end

  // captured data; the full word is kept so a late address sees it unchanged
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wdata_ff <= 32'h0;
    end
    else if (!reg_aresetn_i)
    begin
      wdata_ff <= 32'h0;
    end
    else if (w_take)
    begin
      wdata_ff <= reg_wdata_i;
    end
  end

  // write answer stands until the host takes it
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_bvalid_o <= 1'h0;
    end
    else if (!reg_aresetn_i)
    begin
      reg_bvalid_o <= 1'h0;
    end
    else if (do_write)
    begin
      reg_bvalid_o <= 1'h1;
    end
    else if (reg_bvalid_o && reg_bready_i)
    begin
      reg_bvalid_o <= 1'h0;
    end
  end

  // every write is accepted, reserved address included, so the code is fixed
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_bresp_o <= partition_isolation_pkg::RESP_OKAY;
    end
    else if (!reg_aresetn_i)
    begin
      reg_bresp_o <= partition_isolation_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      reg_bresp_o <= partition_isolation_pkg::RESP_OKAY;
    end
  end

  // write-side values for the current write (fresh or held)
  logic [31:0] wr_data;
  logic        wr_addr;
  assign wr_data = w_seen_ff ? wdata_ff : reg_wdata_i;
  assign wr_addr = aw_seen_ff ? awaddr_ff : reg_awaddr_i;

  // command bit; only bit 0 matters, upper bits are reserved and dropped
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_cmd_ff <= partition_isolation_pkg::DECOUPLE_RESET;
    end
    else if (!reg_aresetn_i)
    begin
      reg_cmd_ff <= partition_isolation_pkg::DECOUPLE_RESET;
    end
    else if (do_write && wr_addr == partition_isolation_pkg::ISOLATION_CMD_OFFSET)
    begin
      reg_cmd_ff <= wr_data[partition_isolation_pkg::CMD_BIT];
    end
  end

  // ==========================================================================
  // register read channel
  // ==========================================================================
  logic        ar_take;
  logic [31:0] rd_word;

  assign ar_take = reg_arvalid_i & reg_arready_o;

  // the state is read back, never the command: writes only reach it via decoupled
  always_comb
  begin
    rd_word = 32'h0;
    if (reg_araddr_i == partition_isolation_pkg::ISOLATION_STATE_OFFSET)
    begin
      rd_word[partition_isolation_pkg::STATE_BIT] = decoupled;
    end
  end

  // read answer stands until the host takes it
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rvalid_o <= 1'h0;
    end
    else if (!reg_aresetn_i)
    begin
      reg_rvalid_o <= 1'h0;
    end
    else if (ar_take)
    begin
      reg_rvalid_o <= 1'h1;
    end
    else if (reg_rvalid_o && reg_rready_i)
    begin
      reg_rvalid_o <= 1'h0;
    end
  end

  // data is frozen at the take edge so a slow host reads a stable word
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= 32'h0;
      reg_rresp_o <= partition_isolation_pkg::RESP_OKAY;
    end
    else if (!reg_aresetn_i)
    begin
      reg_rdata_o <= 32'h0;
      reg_rresp_o <= partition_isolation_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      reg_rdata_o <= rd_word;
      reg_rresp_o <= partition_isolation_pkg::RESP_OKAY;
    end
  end

  assign reg_arready_o = ~reg_rvalid_o;

  // ==========================================================================
  // control and status streams
  // ==========================================================================
  // ready whenever ctrl_aresetn_i is high: only bit 0 of a control word is used, so it needs no buffering
  assign ctrl_tready_o = ctrl_aresetn_i;

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stream_cmd_ff <= partition_isolation_pkg::DECOUPLE_RESET;
    end
    else if (!ctrl_aresetn_i)
    begin
      stream_cmd_ff <= partition_isolation_pkg::DECOUPLE_RESET;
    end
    else if (ctrl_word.valid && ctrl_tready_o)
    begin
      stream_cmd_ff <= ctrl_word.data[partition_isolation_pkg::CMD_BIT];
    end
  end

  // status stream reports the state, one cycle late, every cycle after reset
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status_tvalid_o <= 1'h0;
      status_tdata_o  <= 32'h0;
    end
    else
    begin
      status_tvalid_o <= 1'h1;
      status_tdata_o  <= {31'h0, decoupled};
    end
  end

  // ==========================================================================
  // isolation muxes
  // ==========================================================================
  // one port pair per signal; no crossing here, so no ref clocks or extra status
  // no control reference clock either: the bus clock is always present
  genvar gi;
  generate
    for (gi = 0; gi < TO_RP_W; gi++)
    begin : g_to_rp
      assign rp_to_rp_o[gi] = decoupled ? TO_RP_SAFE[gi % 8] : s_to_rp_i[gi];
    end
    for (gi = 0; gi < FROM_RP_W; gi++)
    begin : g_from_rp
      assign s_from_rp_o[gi] = decoupled ? FROM_RP_SAFE[gi % 8] : rp_from_rp_i[gi];
    end
  endgenerate

endmodule // partition_isolation_control

`default_nettype wire

// ---- tb/partition_far_logic.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// static logic and partition logic stand-in
module partition_far_logic (
  input  wire logic       sys_clk_i,
  output logic      [7:0] static_data_o,
  output logic      [7:0] part_data_o
);
  // the static side changes every cycle, the partition side on all but one cycle in 256, so a stuck mux or a stale safe value shows at once
  initial static_data_o = 8'h5A;
  initial part_data_o = 8'hC3;
  always @(posedge sys_clk_i)
  begin
    static_data_o <= static_data_o + 8'h35;
    part_data_o   <= ~part_data_o ^ static_data_o;
  end
endmodule // partition_far_logic
`default_nettype wire

// ---- tb/partition_isolation_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker for the isolation block
module partition_isolation_asserts #(
  parameter int         TO_RP_W      = 8,
  parameter int         FROM_RP_W    = 8,
  parameter logic [7:0] TO_RP_SAFE   = 8'h00,
  parameter logic [7:0] FROM_RP_SAFE = 8'h00
) (
  input wire logic sys_clk_i, reset_i, reg_aresetn_i, reg_awaddr_i, reg_awvalid_i,
  input wire logic reg_awready_o, reg_wvalid_i, reg_wready_o, reg_bvalid_o, reg_araddr_i,
  input wire logic reg_arvalid_i, reg_arready_o, reg_rvalid_o, reg_rready_i, ctrl_aresetn_i,
  input wire logic ctrl_tvalid_i, ctrl_tready_o, status_tvalid_o, decouple_i, decouple_status_o,
  input wire logic [31:0] reg_wdata_i, reg_rdata_o, ctrl_tdata_i, status_tdata_o,
  input wire logic [1:0] reg_bresp_o,
  input wire logic [TO_RP_W-1:0] s_to_rp_i, rp_to_rp_o,
  input wire logic [FROM_RP_W-1:0] rp_from_rp_i, s_from_rp_o
);
  // one clock domain; the global reset masks every check
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire logic wr_take = reg_awvalid_i & reg_awready_o & reg_wvalid_i & reg_wready_o;

  a_level_forces_on: assert property (decouple_i |-> decouple_status_o)
    else $error("level input ignored");
  a_pass_when_off: assert property (!decouple_status_o |->
    rp_to_rp_o == s_to_rp_i && s_from_rp_o == rp_from_rp_i) else $error("no pass-through");
  a_safe_when_on: assert property (decouple_status_o |->
    rp_to_rp_o == TO_RP_W'(TO_RP_SAFE) && s_from_rp_o == FROM_RP_W'(FROM_RP_SAFE))
    else $error("safe value missing");
  a_read_state: assert property (reg_arvalid_i && reg_arready_o |=> reg_rvalid_o &&
    reg_rdata_o == {31'h0, $past(decouple_status_o) & ~$past(reg_araddr_i)}) else $error("bad read");
  a_write_answer: assert property (wr_take |=> reg_bvalid_o && reg_bresp_o == 2'h0)
    else $error("bad write answer");
  a_write_command: assert property (wr_take && !reg_awaddr_i && reg_wdata_i[0] |=>
    decouple_status_o) else $error("write one did not isolate");
  a_stream_command: assert property (ctrl_tvalid_i && ctrl_tready_o && ctrl_tdata_i[0]
    |=> decouple_status_o) else $error("stream one did not isolate");
  a_status_word: assert property (status_tvalid_o |->
    status_tdata_o == {31'h0, $past(decouple_status_o)}) else $error("bad status word");
  a_stream_reset: assert property (!ctrl_aresetn_i |-> !ctrl_tready_o)
    else $error("stream ready in reset");
  a_reg_reset: assert property (!reg_aresetn_i |=> !reg_bvalid_o && !reg_rvalid_o)
    else $error("register reset ignored");
  a_read_hold: assert property (reg_rvalid_o && !reg_rready_i |=>
    reg_rvalid_o && $stable(reg_rdata_o)) else $error("read answer dropped");

  c_write: cover property (wr_take && reg_wdata_i[0]);
  c_read: cover property (reg_rvalid_o && reg_rdata_o[0]);
  c_stream: cover property (ctrl_tvalid_i && ctrl_tready_o);
endmodule // partition_isolation_asserts

bind partition_isolation_control partition_isolation_asserts #(.TO_RP_W(TO_RP_W),
  .FROM_RP_W(FROM_RP_W), .TO_RP_SAFE(TO_RP_SAFE), .FROM_RP_SAFE(FROM_RP_SAFE)) chk_i (.*);
`default_nettype wire

// ---- tb/partition_isolation_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench with an integer model of the three control sources
module partition_isolation_control_bench;
  logic        clk = 1'h0, rst = 1'h1, reg_rstn = 1'h0, ctrl_rstn = 1'h0, lvl = 1'h0;
  logic        awaddr = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, ta, tw, pa, pw, e;
  logic        araddr = 1'h0, arvalid = 1'h0, rready = 1'h0, tvalid = 1'h0;
  logic [31:0] wdata = 32'h0, tdata = 32'h0, rdata, st_data;
  logic        awready, wready, bvalid, arready, rvalid, tready, st_valid, dstat;
  logic [1:0]  bresp, rresp;
  logic [7:0]  s_in, rp_in, rp_out, s_out;
  int          bad_count = 0, num_checks = 0, reg_cmd = 0, strm_cmd = 0, n;

  // free-running control clock
  always #5 clk = ~clk;
  partition_far_logic far (.sys_clk_i(clk), .static_data_o(s_in), .part_data_o(rp_in));
  partition_isolation_control #(.TO_RP_SAFE(8'hA5), .FROM_RP_SAFE(8'h3C)) dut (
    .sys_clk_i(clk), .reset_i(rst), .reg_aresetn_i(reg_rstn), .reg_awaddr_i(awaddr),
    .reg_awvalid_i(awvalid), .reg_awready_o(awready), .reg_wdata_i(wdata), .reg_wvalid_i(wvalid),
    .reg_wready_o(wready), .reg_bresp_o(bresp), .reg_bvalid_o(bvalid), .reg_bready_i(bready),
    .reg_araddr_i(araddr), .reg_arvalid_i(arvalid), .reg_arready_o(arready), .reg_rdata_o(rdata),
    .reg_rresp_o(rresp), .reg_rvalid_o(rvalid), .reg_rready_i(rready), .ctrl_aresetn_i(ctrl_rstn),
    .ctrl_tvalid_i(tvalid), .ctrl_tready_o(tready), .ctrl_tdata_i(tdata),
    .status_tvalid_o(st_valid), .status_tdata_o(st_data), .decouple_i(lvl),
    .decouple_status_o(dstat), .s_to_rp_i(s_in), .rp_to_rp_o(rp_out), .rp_from_rp_i(rp_in),
    .s_from_rp_o(s_out));

  // ==========================================
  // model, comparison and verdict
  function automatic logic exp_st();
    return reg_cmd != 0 || strm_cmd != 0 || lvl === 1'h1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task fail_if(input logic stuck);
    if (stuck)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  // one idle cycle lets the one-cycle-late status word catch up
  task look;
    @(posedge clk);
    @(negedge clk);
    e = exp_st();
    chk("status", 32'(dstat), 32'(e));
    chk("to_rp", 32'(rp_out), 32'(e ? 8'hA5 : s_in));
    chk("from_rp", 32'(s_out), 32'(e ? 8'h3C : rp_in));
    chk("status_word", st_data, {31'h0, e});
    chk("status_valid", 32'(st_valid), 32'h1);
  endtask

  // ==========================================
  // register and stream transfers
  task wr(input logic a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, pa, pw} <= {a, d, 4'hF};
    @(negedge clk);
    for (n = 0; n < 20 && (pa | pw); n++)
    begin
      ta = pa & awready;
      tw = pw & wready;
      pa = pa & ~ta;
      pw = pw & ~tw;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      @(negedge clk);
    end
    fail_if(pa | pw);
    n = 0;
    while (bvalid !== 1'h1 && ++n < 20) @(negedge clk);
    fail_if(n >= 20);
    if (!a) reg_cmd = d[0];
    chk("bresp", 32'(bresp), 32'h0);
    @(posedge clk) bready <= 1'h1;
    @(posedge clk) bready <= 1'h0;
  endtask
  task rd(input logic a);
    @(posedge clk) {araddr, arvalid} <= {a, 1'h1};
    n = 0;
    do @(negedge clk); while (arready !== 1'h1 && ++n < 20);
    fail_if(n >= 20);
    e = exp_st() & ~a;
    @(posedge clk) arvalid <= 1'h0;
    n = 0;
    do @(negedge clk); while (rvalid !== 1'h1 && ++n < 20);
    fail_if(n >= 20);
    chk("rdata", rdata, {31'h0, e});
    chk("rresp", 32'(rresp), 32'h0);
    @(posedge clk) rready <= 1'h1;
    @(posedge clk) rready <= 1'h0;
  endtask
  task send(input logic [31:0] d);
    @(posedge clk) {tvalid, tdata} <= {1'h1, d};
    n = 0;
    do @(negedge clk); while (tready !== 1'h1 && ++n < 20);
    fail_if(n >= 20);
    strm_cmd = d[0];
    @(posedge clk) tvalid <= 1'h0;
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(32'hC59FFBBF));
    repeat (5) @(posedge clk);
    {rst, reg_rstn, ctrl_rstn} <= 3'h3;
    look();
    wr(1'h0, 32'hFFFFFFFE);
    look();
    wr(1'h0, 32'h1);
    rd(1'h0);
    rd(1'h1);
    wr(1'h1, 32'h0);
    look();
    // single-cycle resets of each port clear only their own command
    @(posedge clk) reg_rstn <= 1'h0;
    @(posedge clk) reg_rstn <= 1'h1;
    reg_cmd = 0;
    look();
    send(32'hFFFF0001);
    look();
    @(posedge clk) ctrl_rstn <= 1'h0;
    @(negedge clk) chk("tready", 32'(tready), 32'h0);
    @(posedge clk) ctrl_rstn <= 1'h1;
    strm_cmd = 0;
    look();
    repeat (60)
    begin
      case ($urandom % 4)
        0: wr(1'($urandom), $urandom);
        1: send($urandom);
        2: @(posedge clk) lvl <= 1'($urandom);
        default: rd(1'($urandom));
      endcase
      look();
    end
    print_verdict();
  end
endmodule // partition_isolation_control_bench
`default_nettype wire
